// ==== hw/amp_cfg_regs.svh ====
`ifndef AMP_CFG_REGS_SVH
`define AMP_CFG_REGS_SVH

// control word layout
`define ACW_WIDTH       16
`define ACW_RESET       16'h0000
`define ACW_GAIN_LSB    0
`define ACW_GAIN_MSB    2
`define ACW_COMP_LSB    3
`define ACW_COMP_MSB    5
`define ACW_SEL_LSB     6
`define ACW_SEL_MSB     7
`define ACW_POL_BIT     8
`define ACW_PDN_BIT     9
`define ACW_FILTER_CAP_ENABLE_BIT    10
`define ACW_FPIN_BIT    11
`define ACW_CUR_LSB     12
`define ACW_CUR_MSB     14
`define ACW_SPARE_BIT   15

// field codes
`define GAIN_EXTERNAL   3'h7
`define CUR_OFF         3'h0
`define CUR_MAX_LEVEL   3'h5
`define CUR_IDLE        3'h6
`define CUR_ILLEGAL     3'h7
`define ATTEN_DIVIDE    50

// amplifier input sources, one bit each
`define SRC_POS_PIN     0
`define SRC_NEG_PIN     1
`define SRC_POS_ATT     2
`define SRC_NEG_ATT     3
`define SRC_VNEG        4
`define SRC_W           5

// power-on settle time
`define POR_DELAY_NS    50000
`define REF_PERIOD_NS   25
`define POR_CYCLES      ((`POR_DELAY_NS + `REF_PERIOD_NS - 1) / `REF_PERIOD_NS)

`endif

// ==== hw/amp_cfg_pkg.sv ====
package amp_cfg_pkg;

    typedef enum logic [1:0]
    {
        SEL_DIFF    = 2'h0,
        SEL_SHORT   = 2'h1,
        SEL_ATT_POS = 2'h2,
        SEL_ATT_NEG = 2'h3
    } input_select_t;

    typedef enum logic [1:0]
    {
        POR_HOLD = 2'h1,
        POR_RUN  = 2'h2
    } por_state_t;

endpackage : amp_cfg_pkg

// ==== hw/pin_sync.sv ====
`timescale 1ns/10ps
`default_nettype none

module pin_sync
#(
    parameter int WIDTH = 1
)
(
    // clock and reset
    input  wire logic             i_ref_clk,
    input  wire logic             i_nrst,
    // pins in, synchronised levels out
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);

    initial
    begin
        if (WIDTH < 1)
            $error("pin_sync: WIDTH must be at least 1");
    end

    genvar g;
    generate
        for (g = 0; g < WIDTH; g++)
        begin : g_bit
            logic meta_ff;
            logic hold_ff;
            always_ff @(posedge i_ref_clk or negedge i_nrst)
            begin
                if (!i_nrst)
                begin
                    meta_ff <= 1'b0;
                    hold_ff <= 1'b0;
                end
                else
                begin
                    meta_ff <= i_async[g];
                    hold_ff <= meta_ff;
                end
            end
            assign o_sync[g] = hold_ff;
        end
    endgenerate

endmodule : pin_sync

`default_nettype wire

// ==== hw/serial_word_shifter.sv ====
`timescale 1ns/10ps
`default_nettype none

module serial_word_shifter
#(
    parameter int WIDTH = 16
)
(
    // clock and reset
    input  wire logic             i_ref_clk,
    input  wire logic             i_nrst,
    // synchronised serial pins
    input  wire logic             i_sclk,
    input  wire logic             i_cs_n,
    input  wire logic             i_sdi,
    input  wire logic             i_enable,
    // assembled word
    output logic                  o_load,
    output logic      [WIDTH-1:0] o_word,
    output logic                  o_sdo
);

    initial
    begin
        if (WIDTH < 2)
            $error("serial_word_shifter: WIDTH must be at least 2");
    end

    logic [WIDTH-1:0] shift_ff;
    logic [WIDTH-1:0] nxt_shift;
    logic             sclk_d_ff;
    logic             cs_d_ff;
    logic             load_ff;
    logic             nxt_load;

    // msb first; word taken when chip select rises
    always_comb
    begin
        nxt_shift = shift_ff;
        nxt_load  = 1'b0;
        if (i_enable && !i_cs_n && i_sclk && !sclk_d_ff)
            nxt_shift = {shift_ff[WIDTH-2:0], i_sdi};
        if (i_enable && i_cs_n && !cs_d_ff)
            nxt_load = 1'b1;
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            shift_ff  <= '0;
            sclk_d_ff <= 1'b0;
            cs_d_ff   <= 1'b1;
            load_ff   <= 1'b0;
        end
        else
        begin
            shift_ff  <= nxt_shift;
            sclk_d_ff <= i_sclk;
            cs_d_ff   <= i_cs_n;
            load_ff   <= nxt_load;
        end
    end

    assign o_load = load_ff;
    assign o_word = shift_ff;
    // daisy chain output
    assign o_sdo  = shift_ff[WIDTH-1];

endmodule : serial_word_shifter

`default_nettype wire

// ==== hw/amp_config_field_decode.sv ====
// Overview of operation
// - select 01, polarity 0: both amp inputs take positive pin; negative floats
// - select 01, polarity 1: both amp inputs take negative pin; positive floats
// - select 10/11: one pin floats, other through divide-by-50; 10 positive, 11 negative
// - attenuated modes: amp input not fed by the pin goes to negative supply
// - attenuated gains 0.2..20 for codes 000..110; polarity 1 negates them
// - bit 9 high puts the amplifier in shutdown, low keeps it active
// - bit 10 opens feedback switch when 0, closes when 1, gain codes 000..110
// - gain code 111 keeps feedback switch closed regardless of bit 10
// - bit 11 steers fault current to positive (0) or negative (1) pin
// - bits 14:12 fault current: off, five levels, idle powered; 111 never written
// - bits 2:0 gain code; 111 selects external resistor gain
// - polarity and input select sit in bits 8:6
// - select 00 is normal differential; polarity 1 swaps the pins
// - control word held at zero until 50 us after power comes up
`timescale 1ns/10ps
`default_nettype none
`include "amp_cfg_regs.svh"

module amp_config_field_decode
    import amp_cfg_pkg::*;
#(
    parameter int WORD_W     = `ACW_WIDTH,
    parameter int POR_CYCLES = `POR_CYCLES
)
(
    // clock and reset
    input  wire logic              i_ref_clk,
    input  wire logic              i_nrst,
    // serial control pins
    input  wire logic              i_sclk,
    input  wire logic              i_cs_n,
    input  wire logic              i_sdi,
    output logic                   o_sdo,
    // power-on status
    output logic                   o_por_done,
    // amplifier input routing
    output logic [`SRC_W-1:0]      o_amp_pos_src,
    output logic [`SRC_W-1:0]      o_amp_neg_src,
    output logic                   o_pos_pin_float,
    output logic                   o_neg_pin_float,
    output logic                   o_atten_en,
    output logic                   o_gain_negate,
    // gain and compensation
    output logic [2:0]             o_gain_code,
    output logic [2:0]             o_comp_code,
    output logic                   o_internal_gain_switch,
    output logic                   o_feedback_switch,
    // power
    output logic                   o_power_down,
    // fault current source
    output logic                   o_fault_src_to_pos,
    output logic                   o_fault_src_to_neg,
    output logic [2:0]             o_fault_current_level,
    output logic                   o_fault_src_powered,
    output logic                   o_fault_code_illegal
);

    initial
    begin
        if (WORD_W != `ACW_WIDTH)
            $error("amp_config_field_decode: WORD_W must be 16");
        if (POR_CYCLES < 1 || POR_CYCLES > 65535)
            $error("amp_config_field_decode: POR_CYCLES out of range");
    end

    // route both amplifier inputs from select and polarity
    function automatic logic [2*`SRC_W-1:0] route(input logic [1:0] sel, input logic polarity_invert);
        logic [`SRC_W-1:0] p;
        logic [`SRC_W-1:0] n;
        p = '0;
        n = '0;
        unique case (input_select_t'(sel))
            SEL_DIFF:
            begin
                p[polarity_invert ? `SRC_NEG_PIN : `SRC_POS_PIN] = 1'b1;
                n[polarity_invert ? `SRC_POS_PIN : `SRC_NEG_PIN] = 1'b1;
            end
            SEL_SHORT:
            begin
                p[polarity_invert ? `SRC_NEG_PIN : `SRC_POS_PIN] = 1'b1;
                n[polarity_invert ? `SRC_NEG_PIN : `SRC_POS_PIN] = 1'b1;
            end
            SEL_ATT_POS:
            begin
                p[polarity_invert ? `SRC_VNEG : `SRC_POS_ATT] = 1'b1;
                n[polarity_invert ? `SRC_POS_ATT : `SRC_VNEG] = 1'b1;
            end
            SEL_ATT_NEG:
            begin
                p[polarity_invert ? `SRC_VNEG : `SRC_NEG_ATT] = 1'b1;
                n[polarity_invert ? `SRC_NEG_ATT : `SRC_VNEG] = 1'b1;
            end
        endcase
        return {p, n};
    endfunction : route

    // synchronised pins
    logic       sclk_s;
    logic       cs_act_s; // inverted so reset matches idle select
    logic       sdi_s;

    pin_sync
    #(
        .WIDTH (3)
    )
    u_pin_sync
    (
        .i_ref_clk (i_ref_clk),
        .i_nrst    (i_nrst),
        .i_async   ({i_sclk, ~i_cs_n, i_sdi}),
        .o_sync    ({sclk_s, cs_act_s, sdi_s})
    );

    // power-on hold
    por_state_t  por_state_ff;
    por_state_t  nxt_por_state;
    logic [15:0] por_cnt_ff;
    logic [15:0] nxt_por_cnt;
    logic        por_done_ff;
    logic        nxt_por_done;

    always_comb
    begin
        nxt_por_state = por_state_ff;
        nxt_por_cnt   = por_cnt_ff;
        nxt_por_done  = 1'b0;
        unique case (por_state_ff)
            POR_HOLD:
            begin
                nxt_por_cnt = por_cnt_ff + 16'h0001;
                if (por_cnt_ff == 16'(POR_CYCLES - 1))
                begin
                    nxt_por_state = POR_RUN;
                    nxt_por_done  = 1'b1;
                end
            end
            POR_RUN:
            begin
                nxt_por_done = 1'b1;
            end
            default:
            begin
                nxt_por_state = POR_HOLD;
                nxt_por_cnt   = 16'h0000;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            por_state_ff <= POR_HOLD;
            por_cnt_ff   <= 16'h0000;
            por_done_ff  <= 1'b0;
        end
        else
        begin
            por_state_ff <= nxt_por_state;
            por_cnt_ff   <= nxt_por_cnt;
            por_done_ff  <= nxt_por_done;
        end
    end

    // serial word assembly
    logic              shift_load;
    logic [WORD_W-1:0] shift_word;

    serial_word_shifter
    #(
        .WIDTH (WORD_W)
    )
    u_shifter
    (
        .i_ref_clk (i_ref_clk),
        .i_nrst    (i_nrst),
        .i_sclk    (sclk_s),
        .i_cs_n    (~cs_act_s),
        .i_sdi     (sdi_s),
        .i_enable  (por_done_ff),
        .o_load    (shift_load),
        .o_word    (shift_word),
        .o_sdo     (o_sdo)
    );

    // stored control word and decoded controls
    logic [WORD_W-1:0] word_ff;
    logic [WORD_W-1:0] nxt_word;
    logic [1:0]        w_sel;
    logic              w_pol;
    logic [2:0]        w_gain;
    logic [2:0]        w_cur;
    logic [2*`SRC_W-1:0] w_route;
    logic [`SRC_W-1:0] amp_pos_ff;
    logic [`SRC_W-1:0] amp_neg_ff;
    logic              pos_float_ff;
    logic              neg_float_ff;
    logic              atten_ff;
    logic              negate_ff;
    logic [2:0]        gain_ff;
    logic [2:0]        comp_ff;
    logic              igs_ff;
    logic              fbs_ff;
    logic              pdn_ff;
    logic              fpos_ff;
    logic              fneg_ff;
    logic [2:0]        cur_ff;
    logic              fpwr_ff;
    logic              fbad_ff;
    logic [`SRC_W-1:0] nxt_amp_pos;
    logic [`SRC_W-1:0] nxt_amp_neg;
    logic              nxt_pos_float;
    logic              nxt_neg_float;
    logic              nxt_atten;
    logic              nxt_negate;
    logic [2:0]        nxt_gain;
    logic [2:0]        nxt_comp;
    logic              nxt_igs;
    logic              nxt_fbs;
    logic              nxt_pdn;
    logic              nxt_fpos;
    logic              nxt_fneg;
    logic [2:0]        nxt_cur;
    logic              nxt_fpwr;
    logic              nxt_fbad;

    always_comb
    begin
        nxt_word = word_ff;
        if (!por_done_ff)
            nxt_word = `ACW_RESET;
        else if (shift_load)
            nxt_word = shift_word;
        // decode from the next word so controls move with the load
        w_gain  = nxt_word[`ACW_GAIN_MSB:`ACW_GAIN_LSB];
        w_sel   = nxt_word[`ACW_SEL_MSB:`ACW_SEL_LSB];
        w_pol   = nxt_word[`ACW_POL_BIT];
        w_cur   = nxt_word[`ACW_CUR_MSB:`ACW_CUR_LSB];
        w_route = route(w_sel, w_pol);
        // bit 15 is never looked at
        nxt_amp_pos = w_route[2*`SRC_W-1:`SRC_W];
        nxt_amp_neg = w_route[`SRC_W-1:0];
        nxt_pos_float = (w_sel == SEL_ATT_NEG) ||
                        (w_sel == SEL_SHORT && w_pol);
        nxt_neg_float = (w_sel == SEL_ATT_POS) ||
                        (w_sel == SEL_SHORT && !w_pol);
        nxt_atten     = w_sel[1];
        nxt_negate    = w_pol;
        nxt_gain = w_gain;
        nxt_comp = nxt_word[`ACW_COMP_MSB:`ACW_COMP_LSB];
        nxt_igs  = (w_gain != `GAIN_EXTERNAL);
        nxt_fbs  = (w_gain == `GAIN_EXTERNAL) ? 1'b1
                 : nxt_word[`ACW_FILTER_CAP_ENABLE_BIT];
        nxt_pdn  = nxt_word[`ACW_PDN_BIT];
        // fault current: illegal code handled as off
        nxt_fbad = (w_cur == `CUR_ILLEGAL);
        nxt_cur  = nxt_fbad ? `CUR_OFF : w_cur;
        nxt_fpwr = (nxt_cur != `CUR_OFF);
        nxt_fpos = (nxt_cur != `CUR_OFF) && (nxt_cur <= `CUR_MAX_LEVEL) &&
                   !nxt_word[`ACW_FPIN_BIT];
        nxt_fneg = (nxt_cur != `CUR_OFF) && (nxt_cur <= `CUR_MAX_LEVEL) &&
                   nxt_word[`ACW_FPIN_BIT];
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            word_ff      <= `ACW_RESET;
            amp_pos_ff   <= 5'h01;
            amp_neg_ff   <= 5'h02;
            pos_float_ff <= 1'b0;
            neg_float_ff <= 1'b0;
            atten_ff     <= 1'b0;
            negate_ff    <= 1'b0;
            gain_ff      <= 3'h0;
            comp_ff      <= 3'h0;
            igs_ff       <= 1'b1;
            fbs_ff       <= 1'b0;
            pdn_ff       <= 1'b0;
            fpos_ff      <= 1'b0;
            fneg_ff      <= 1'b0;
            cur_ff       <= 3'h0;
            fpwr_ff      <= 1'b0;
            fbad_ff      <= 1'b0;
        end
        else
        begin
            word_ff      <= nxt_word;
            amp_pos_ff   <= nxt_amp_pos;
            amp_neg_ff   <= nxt_amp_neg;
            pos_float_ff <= nxt_pos_float;
            neg_float_ff <= nxt_neg_float;
            atten_ff     <= nxt_atten;
            negate_ff    <= nxt_negate;
            gain_ff      <= nxt_gain;
            comp_ff      <= nxt_comp;
            igs_ff       <= nxt_igs;
            fbs_ff       <= nxt_fbs;
            pdn_ff       <= nxt_pdn;
            fpos_ff      <= nxt_fpos;
            fneg_ff      <= nxt_fneg;
            cur_ff       <= nxt_cur;
            fpwr_ff      <= nxt_fpwr;
            fbad_ff      <= nxt_fbad;
        end
    end

    assign o_por_done             = por_done_ff;
    assign o_amp_pos_src          = amp_pos_ff;
    assign o_amp_neg_src          = amp_neg_ff;
    assign o_pos_pin_float        = pos_float_ff;
    assign o_neg_pin_float        = neg_float_ff;
    assign o_atten_en             = atten_ff;
    assign o_gain_negate          = negate_ff;
    assign o_gain_code            = gain_ff;
    assign o_comp_code            = comp_ff;
    assign o_internal_gain_switch = igs_ff;
    assign o_feedback_switch      = fbs_ff;
    assign o_power_down           = pdn_ff;
    assign o_fault_src_to_pos     = fpos_ff;
    assign o_fault_src_to_neg     = fneg_ff;
    assign o_fault_current_level  = cur_ff;
    assign o_fault_src_powered    = fpwr_ff;
    assign o_fault_code_illegal   = fbad_ff;

endmodule : amp_config_field_decode

`default_nettype wire

// ==== bench/amp_cfg_asserts.sv ====
`timescale 1ns/10ps
`default_nettype none

module amp_cfg_asserts
#(
    parameter int POR_CYCLES = 4
)
(
    input wire logic       i_ref_clk,
    input wire logic       i_nrst,
    input wire logic       o_por_done,
    input wire logic [4:0] o_amp_pos_src,
    input wire logic [4:0] o_amp_neg_src,
    input wire logic       o_pos_pin_float,
    input wire logic       o_neg_pin_float,
    input wire logic       o_atten_en,
    input wire logic       o_gain_negate,
    input wire logic [2:0] o_gain_code,
    input wire logic       o_internal_gain_switch,
    input wire logic       o_feedback_switch,
    input wire logic       o_fault_src_to_pos,
    input wire logic       o_fault_src_to_neg,
    input wire logic [2:0] o_fault_current_level,
    input wire logic       o_fault_src_powered,
    input wire logic       o_fault_code_illegal
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_nrst);

    logic [15:0] hold_cnt_ff;
    logic [15:0] nxt_hold_cnt;

    always_comb nxt_hold_cnt = o_por_done ? 16'h0000 : hold_cnt_ff + 16'h0001;

    always_ff @(posedge i_ref_clk or negedge i_nrst)
    begin
        if (!i_nrst) hold_cnt_ff <= 16'h0000;
        else hold_cnt_ff <= nxt_hold_cnt;
    end

    AST_POR_HOLD: assert property (hold_cnt_ff <= POR_CYCLES + 2)
        else $error("power-on hold too long");
    AST_POR_STAYS: assert property (o_por_done |=> o_por_done)
        else $error("power-on done dropped");
    AST_POR_CLEAR: assert property (!o_por_done |-> o_gain_code == 3'h0 &&
        o_amp_pos_src == 5'h01 && o_amp_neg_src == 5'h02 && !o_fault_src_powered)
        else $error("word not clear during hold");
    AST_SHORT_POS: assert property ((o_amp_pos_src == 5'h01 && o_amp_neg_src == 5'h01)
        |-> o_neg_pin_float && !o_pos_pin_float && !o_atten_en)
        else $error("short mode pins wrong");
    AST_ATT_VNEG: assert property (o_atten_en |->
        ((o_amp_pos_src == 5'h10) != (o_amp_neg_src == 5'h10)) &&
        (o_pos_pin_float != o_neg_pin_float))
        else $error("attenuated mode routing wrong");
    AST_ATT_SIGN: assert property (o_atten_en |-> o_gain_negate == (o_amp_pos_src == 5'h10))
        else $error("attenuated sign wrong");
    AST_EXT_GAIN: assert property (o_gain_code == 3'h7 |->
        o_feedback_switch && !o_internal_gain_switch)
        else $error("external gain switches wrong");
    AST_FAULT_PIN: assert property ((o_fault_src_to_pos || o_fault_src_to_neg) |->
        !(o_fault_src_to_pos && o_fault_src_to_neg) &&
        o_fault_current_level >= 3'h1 && o_fault_current_level <= 3'h5)
        else $error("fault source connection wrong");
    AST_ILLEGAL: assert property (o_fault_code_illegal |->
        o_fault_current_level == 3'h0 && !o_fault_src_powered)
        else $error("illegal current code not off");
    AST_TOGETHER: assert property ($changed(o_gain_code) |=> $stable(o_gain_code) [*8])
        else $error("gain code changed twice");
endmodule : amp_cfg_asserts

bind amp_config_field_decode amp_cfg_asserts #(.POR_CYCLES(POR_CYCLES)) u_asserts
(
    .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .o_por_done(o_por_done),
    .o_amp_pos_src(o_amp_pos_src), .o_amp_neg_src(o_amp_neg_src),
    .o_pos_pin_float(o_pos_pin_float), .o_neg_pin_float(o_neg_pin_float),
    .o_atten_en(o_atten_en), .o_gain_negate(o_gain_negate), .o_gain_code(o_gain_code),
    .o_internal_gain_switch(o_internal_gain_switch), .o_feedback_switch(o_feedback_switch),
    .o_fault_src_to_pos(o_fault_src_to_pos), .o_fault_src_to_neg(o_fault_src_to_neg),
    .o_fault_current_level(o_fault_current_level), .o_fault_src_powered(o_fault_src_powered),
    .o_fault_code_illegal(o_fault_code_illegal)
);

`default_nettype wire

// ==== bench/serial_host_model.sv ====
`timescale 1ns/10ps
`default_nettype none

module serial_host_model
(
    input  wire logic i_ref_clk,
    output var logic  o_sclk,
    output var logic  o_cs_n,
    output var logic  o_sdi
);
    initial
    begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_sdi  = 1'b0;
    end

    // msb first, 4 clocks per phase, clock parked low outside frames
    task automatic write_word(input logic [15:0] w);
        @(posedge i_ref_clk);
        o_cs_n <= 1'b0;
        for (int b = 15; b >= 0; b--)
        begin
            o_sdi <= w[b];
            repeat (4) @(posedge i_ref_clk);
            o_sclk <= 1'b1;
            repeat (4) @(posedge i_ref_clk);
            o_sclk <= 1'b0;
        end
        repeat (4) @(posedge i_ref_clk);
        o_cs_n <= 1'b1;
        // released data line shows the inverse of its last bit
        o_sdi  <= ~w[0];
        repeat (4) @(posedge i_ref_clk);
    endtask : write_word
endmodule : serial_host_model

`default_nettype wire

// ==== bench/amp_config_field_decode_test.sv ====
`timescale 1ns/10ps
`default_nettype none

module amp_config_field_decode_test;
    localparam int POR_N = 4;
    localparam logic [4:0] POS_T [8] = '{5'h01, 5'h02, 5'h01, 5'h02, 5'h04, 5'h10, 5'h08, 5'h10};
    localparam logic [4:0] NEG_T [8] = '{5'h02, 5'h01, 5'h01, 5'h02, 5'h10, 5'h04, 5'h10, 5'h08};
    localparam logic [7:0] PF_T = 8'b1100_1000;
    localparam logic [7:0] NF_T = 8'b0011_0100;

    logic       i_ref_clk = 1'b0;
    logic       i_nrst = 1'b0;
    logic       sclk, cs_n, sdi, sdo, por_done, pos_fl, neg_fl, atten, negate;
    logic       igs, fbs, pdn, f_pos, f_neg, f_pwr, f_ill;
    logic [4:0] pos_src, neg_src;
    logic [2:0] gain, comp, f_lvl;
    int         n_errors = 0;
    int         num_checks = 0;

    always #12.5 i_ref_clk = ~i_ref_clk;

    serial_host_model host (.i_ref_clk(i_ref_clk), .o_sclk(sclk), .o_cs_n(cs_n), .o_sdi(sdi));

    amp_config_field_decode #(.POR_CYCLES(POR_N)) uut
    (
        .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_sclk(sclk), .i_cs_n(cs_n), .i_sdi(sdi),
        .o_sdo(sdo), .o_por_done(por_done), .o_amp_pos_src(pos_src), .o_amp_neg_src(neg_src),
        .o_pos_pin_float(pos_fl), .o_neg_pin_float(neg_fl), .o_atten_en(atten),
        .o_gain_negate(negate), .o_gain_code(gain), .o_comp_code(comp),
        .o_internal_gain_switch(igs), .o_feedback_switch(fbs), .o_power_down(pdn),
        .o_fault_src_to_pos(f_pos), .o_fault_src_to_neg(f_neg), .o_fault_current_level(f_lvl),
        .o_fault_src_powered(f_pwr), .o_fault_code_illegal(f_ill)
    );

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic give_verdict;
        if (n_errors == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : give_verdict

    task automatic wr(input logic [15:0] w);
        host.write_word(w);
        repeat (3) @(posedge i_ref_clk);
    endtask : wr

    task automatic do_reset;
        @(posedge i_ref_clk);
        i_nrst <= 1'b0;
        repeat (5) @(posedge i_ref_clk);
        i_nrst <= 1'b1;
        for (int k = 0; k < POR_N + 10 && por_done !== 1'b1; k++) @(posedge i_ref_clk);
        @(posedge i_ref_clk);
    endtask : do_reset

    task automatic check_route(input int i);
        check("pos_src", 16'(POS_T[i]), 16'(pos_src));
        check("neg_src", 16'(NEG_T[i]), 16'(neg_src));
        check("pos_float", 16'(PF_T[i]), 16'(pos_fl));
        check("neg_float", 16'(NF_T[i]), 16'(neg_fl));
        check("atten", 16'(i >= 4), 16'(atten));
        check("negate", 16'(i % 2), 16'(negate));
    endtask : check_route

    task automatic t_reset;
        do_reset();
        check("por_done", 16'h0001, 16'(por_done));
        check_route(0);
        wr(16'h5207);
        check("gain", 16'h0007, 16'(gain));
        do_reset();
        check("gain", 16'h0000, 16'(gain));
        check("power_down", 16'h0000, 16'(pdn));
        check("fault_pwr", 16'h0000, 16'(f_pwr));
    endtask : t_reset

    task automatic t_mux;
        for (int i = 0; i < 8; i++)
        begin
            // select 10/11 with polarity 0 gives the range test words
            wr({7'h00, 1'(i % 2), 2'(i / 2), 6'h02});
            check_route(i);
        end
    endtask : t_mux

    task automatic t_gain;
        for (int i = 0; i < 16; i++)
        begin
            // bit 15, filter and power-down bits each follow their own pattern
            wr({1'(i / 8), 4'h0, 1'(i % 2), 1'((i / 4) % 2), 3'h0, 3'(i / 2), 3'(i / 2)});
            check("sdo", 16'(i / 8), 16'(sdo));
            check("gain", 16'(i / 2), 16'(gain));
            check("comp", 16'(i / 2), 16'(comp));
            check("int_sw", 16'(i / 2 != 7), 16'(igs));
            check("fb_sw", 16'(i / 2 == 7 || i % 2 == 1), 16'(fbs));
            check("power_down", 16'((i / 4) % 2), 16'(pdn));
            check_route(0);
        end
    endtask : t_gain

    task automatic t_fault;
        int lvl;
        for (int i = 0; i < 16; i++)
        begin
            lvl = (i / 2 == 7) ? 0 : i / 2;
            // code 111 sent on purpose to see it refused
            wr({1'b0, 3'(i / 2), 1'(i % 2), 11'h000});
            check("level", 16'(lvl), 16'(f_lvl));
            check("powered", 16'(lvl != 0), 16'(f_pwr));
            check("illegal", 16'(i / 2 == 7), 16'(f_ill));
            check("to_pos", 16'(lvl inside {[1:5]} && i % 2 == 0), 16'(f_pos));
            check("to_neg", 16'(lvl inside {[1:5]} && i % 2 == 1), 16'(f_neg));
        end
    endtask : t_fault

    task automatic t_diag;
        logic [15:0] words [3];
        int          route [3];
        words = '{16'h5082, 16'h58C2, 16'h5000};
        route = '{4, 6, 0};
        // back-to-back pair of the degraded line test, then normal differential inputs
        for (int i = 0; i < 3; i++)
        begin
            wr(words[i]);
            check_route(route[i]);
            check("level", 16'h0005, 16'(f_lvl));
            check("to_pos", 16'(i != 1), 16'(f_pos));
            check("to_neg", 16'(i == 1), 16'(f_neg));
            check("gain", 16'(i == 2 ? 0 : 2), 16'(gain));
        end
    endtask : t_diag

    initial
    begin
        t_reset();
        t_mux();
        t_gain();
        t_fault();
        t_diag();
        give_verdict();
    end

    initial
    begin
        repeat (20000) @(posedge i_ref_clk);
        n_errors++;
        give_verdict();
    end
endmodule : amp_config_field_decode_test

`default_nettype wire
